// [rtl/arb_defines.svh]
// timing counts and encodings for the local bus request/grant logic
`ifndef ARB_DEFINES_SVH
`define ARB_DEFINES_SVH

`define CLK_PERIOD_NS      10
`define PULSE_TIME_NS      10
`define PULSE_CYCLES       ((`PULSE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_TIME_NS        10
`define GAP_CYCLES         ((`GAP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IDLE_START_CLOCKS  3
`define EXCHANGE_PULSES    3
`define NUM_CHANNELS       2

`define QS_NO_OP           2'h0
`define QS_FIRST_BYTE      2'h1
`define QS_EMPTIED         2'h2
`define QS_NEXT_BYTE       2'h3

`endif

// [rtl/arb_pkg.sv]
// types shared by the request/grant logic
package arb_pkg;

  typedef enum logic [2:0] {st_idle, st_t1, st_t2, st_t3, st_t4} bus_state_t;

  typedef enum logic [1:0] {op_none, op_first, op_empty, op_next} queue_op_t;

  typedef struct packed {
    bus_state_t bus_state;
    logic       cycle_pending;
    logic       odd_low_byte;
    logic       interrupt_acknowledge_cycle_first;
    logic       interrupt_acknowledge_cycle_second;
    logic       lock_prefix;
    queue_op_t  queue_op;
  } core_status_t;

  typedef struct packed {
    logic       pin_in;
    logic       pin_out;
    logic       pin_oe;
  } rg_pin_t;

endpackage

// [rtl/rg_channel.sv]
// one request/grant pin: request capture, grant pulse, release capture
`include "arb_defines.svh"

module rg_channel
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic pin_in,
  input  wire logic grant_go,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      waiting,
  output logic      holding,
  output logic      release_seen
);
  import arb_pkg::*;

  typedef enum logic [2:0] {ch_idle, ch_wait, ch_grant, ch_hold, ch_gap} ch_state_t;

  ch_state_t state_reg;
  ch_state_t state_next;
  logic      oe_reg;

  wire req_seen   = (state_reg == ch_idle) && !pin_in;
  assign release_seen = (state_reg == ch_hold) && !pin_in;
  assign waiting  = (state_reg == ch_wait);
  assign holding  = (state_reg == ch_grant) || (state_reg == ch_hold);
  assign pin_oe   = oe_reg;
  assign pin_out  = 1'b0;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ch_idle:  if (req_seen) state_next = ch_wait;           // RULE1
      ch_wait:  if (grant_go) state_next = ch_grant;
      ch_grant: state_next = ch_hold;
      ch_hold:  if (release_seen) state_next = ch_gap;        // RULE3
      ch_gap:   state_next = ch_idle;                         // RULE6
      default:  state_next = ch_idle;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ch_idle;
      oe_reg    <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      oe_reg    <= (state_reg == ch_wait) && grant_go;        // RULE5
    end
  end

  // pin is only pulled low by us, one clock, and only after a request
  grant_width_a: assert property (@(posedge clock) disable iff (rst)
    oe_reg |=> !oe_reg)
    else $error("grant pulse wider than one clock"); // RULE5
  gap_after_a: assert property (@(posedge clock) disable iff (rst)
    release_seen |=> (state_reg == ch_gap) ##1 (state_reg == ch_idle))
    else $error("no idle clock after exchange"); // RULE6

endmodule // rg_channel

// [rtl/local_bus_request_grant_lock.sv]
// local bus request/grant arbitration, bus lock and queue status outputs
`include "arb_defines.svh"

// Summary of operation
// RULE1 - other master requests with a one-clock low pulse on its request/grant pin
// RULE2 - after granting, enter grant sequence next clock and float the bus interface
// RULE3 - a one-clock release pulse ends the hold; bus reclaimed at next edge
// RULE4 - on reclaim, core resumes in final state or idle if nothing pending
// RULE5 - each exchange is exactly three low pulses: request, grant, release
// RULE6 - at least one idle clock separates consecutive exchanges
// RULE7 - request during a memory cycle releases the bus in its final state
// RULE8 - release needs early request, not odd low byte, not first acknowledge, not locked
// RULE9 - request on an idle bus releases the bus in the next cycle
// RULE10 - a cycle starting soon after an idle request counts the request as early
// RULE11 - drive active-low lock to keep other masters off the system bus
// RULE12 - lock prefix holds lock until the following instruction completes
// RULE13 - during grant sequence lock is released to high impedance, reading one
// RULE14 - lock set in second state of first acknowledge, cleared in second's
// RULE15 - queue status valid the clock after the queue operation
// RULE16 - queue status outputs are always driven
// RULE17 - queue codes: none, first opcode byte, emptied, subsequent byte
module local_bus_request_grant_lock
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire arb_pkg::core_status_t core_status,
  input  wire logic                 req_grant_pin_high_prio_in,
  output logic                      req_grant_pin_high_prio_out,
  output logic                      req_grant_pin_high_prio_oe,
  input  wire logic                 req_grant_pin_low_prio_in,
  output logic                      req_grant_pin_low_prio_out,
  output logic                      req_grant_pin_low_prio_oe,
  output logic                      bus_float,
  output logic                      resume_in_final_state,
  output logic                      lock_n_out,
  output logic                      lock_n_oe,
  output logic                      queue_status_msb,
  output logic                      queue_status_lsb
);
  import arb_pkg::*;

  logic [`NUM_CHANNELS-1:0] pin_in;
  logic [`NUM_CHANNELS-1:0] pin_out;
  logic [`NUM_CHANNELS-1:0] pin_oe;
  logic [`NUM_CHANNELS-1:0] waiting;
  logic [`NUM_CHANNELS-1:0] holding;
  logic [`NUM_CHANNELS-1:0] release_seen;
  logic [`NUM_CHANNELS-1:0] grant_go;

  logic       float_reg;
  logic       float_next;
  logic       early_reg;
  logic       early_next;
  logic       interrupt_acknowledge_cycle_lock_reg;
  logic       interrupt_acknowledge_cycle_lock_next;
  logic       lock_n_reg;
  logic       lock_oe_reg;
  logic       resume_final_reg;
  logic [1:0] qs_reg;
  logic [1:0] qs_next;
  logic [2:0] idle_wait_reg;
  logic [2:0] idle_wait_next;

  assign pin_in[0] = req_grant_pin_high_prio_in;
  assign pin_in[1] = req_grant_pin_low_prio_in;

  genvar g;
  generate
    for (g = 0; g < `NUM_CHANNELS; g = g + 1)
    begin : gen_ch
      rg_channel u_ch
      (
        .clock        (clock),
        .rst          (rst),
        .pin_in       (pin_in[g]),
        .grant_go     (grant_go[g]),
        .pin_out      (pin_out[g]),
        .pin_oe       (pin_oe[g]),
        .waiting      (waiting[g]),
        .holding      (holding[g]),
        .release_seen (release_seen[g])
      );
    end
  endgenerate

  // pin enables come straight from the channel flip-flops; pin data is tied low
  assign req_grant_pin_high_prio_out = pin_out[0];
  assign req_grant_pin_high_prio_oe  = pin_oe[0];
  assign req_grant_pin_low_prio_out  = pin_out[1];
  assign req_grant_pin_low_prio_oe   = pin_oe[1];

  wire bus_state_t bs       = core_status.bus_state;
  wire req_any              = |waiting;
  wire bus_busy             = (|holding) || float_reg;
  wire in_early_state       = (bs == st_t1) || (bs == st_t2);
  wire locked_exec          = core_status.lock_prefix || interrupt_acknowledge_cycle_lock_reg;
  // idle grant is withheld while the core has a cycle about to start
  wire idle_release         = (bs == st_idle) && !core_status.cycle_pending;          // RULE9
  wire mem_conditions       = !core_status.odd_low_byte && !core_status.interrupt_acknowledge_cycle_first
                              && !locked_exec;                                         // RULE8
  wire mem_release          = (bs == st_t4) && early_reg && mem_conditions;           // RULE7
  wire release_ok           = !bus_busy && (idle_release || mem_release);

  // fixed priority: the high priority pin wins a tie
  assign grant_go[0] = waiting[0] && release_ok;
  assign grant_go[1] = waiting[1] && !waiting[0] && release_ok;

  wire any_grant   = |grant_go;
  wire any_release = |release_seen;

  // a request seen on an idle bus stays early for the next cycle start
  always_comb
  begin
    early_next     = early_reg;
    idle_wait_next = idle_wait_reg;
    // an idle-bus request is marked early within the idle window and stays early for a cycle starting after it
    if (req_any && (in_early_state || (bs == st_idle && idle_wait_reg < 3'(`IDLE_START_CLOCKS))))
      early_next = 1'b1;                                                               // RULE10
    else if (bs == st_t4 || !req_any)
      early_next = 1'b0;
    if (req_any && bs == st_idle && idle_wait_reg < 3'(`IDLE_START_CLOCKS))
      idle_wait_next = idle_wait_reg + 3'h1;
    else if (!req_any || bs != st_idle)
      idle_wait_next = 3'h0;
  end

  assign float_next     = any_grant ? 1'b1 : (any_release ? 1'b0 : float_reg);      // RULE2 RULE3
  assign interrupt_acknowledge_cycle_lock_next = (bs == st_t2 && core_status.interrupt_acknowledge_cycle_first)  ? 1'b1 :
                          (bs == st_t2 && core_status.interrupt_acknowledge_cycle_second) ? 1'b0 :
                          interrupt_acknowledge_cycle_lock_reg;                                               // RULE14

  always_comb
  begin
    case (core_status.queue_op)
      op_none:  qs_next = `QS_NO_OP;                                                   // RULE17
      op_first: qs_next = `QS_FIRST_BYTE;
      op_empty: qs_next = `QS_EMPTIED;
      op_next:  qs_next = `QS_NEXT_BYTE;
      default:  qs_next = `QS_NO_OP;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      float_reg        <= 1'b0;
      early_reg        <= 1'b0;
      idle_wait_reg    <= 3'h0;
      interrupt_acknowledge_cycle_lock_reg    <= 1'b0;
      lock_n_reg       <= 1'b1;
      lock_oe_reg      <= 1'b1;
      resume_final_reg <= 1'b0;
      qs_reg           <= `QS_NO_OP;
    end
    else
    begin
      float_reg        <= float_next;
      early_reg        <= early_next;
      idle_wait_reg    <= idle_wait_next;
      interrupt_acknowledge_cycle_lock_reg    <= interrupt_acknowledge_cycle_lock_next;
      lock_n_reg       <= float_next || !(core_status.lock_prefix || interrupt_acknowledge_cycle_lock_next); // RULE11 RULE12 RULE13
      lock_oe_reg      <= !float_next;                                                 // RULE13
      resume_final_reg <= any_release && core_status.cycle_pending;                   // RULE4
      qs_reg           <= qs_next;                                                     // RULE15 RULE16
    end
  end

  assign bus_float             = float_reg;
  assign resume_in_final_state = resume_final_reg;
  assign lock_n_out            = lock_n_reg;
  assign lock_n_oe             = lock_oe_reg;
  assign queue_status_msb      = qs_reg[1];
  assign queue_status_lsb      = qs_reg[0];

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  float_after_a:     assert property (any_grant |=> bus_float ##1 bus_float)
    else $error("bus not floated after grant"); // RULE2
  reclaim_next_a:    assert property (any_release |=> !bus_float)
    else $error("bus not reclaimed after release"); // RULE3
  grant_pulse_a:     assert property (any_grant |=> (req_grant_pin_high_prio_oe || req_grant_pin_low_prio_oe))
    else $error("grant pulse missing"); // RULE5
  mem_release_a:     assert property (any_grant |-> (bs == st_idle || (bs == st_t4 && early_reg)))
    else $error("grant outside final or idle state"); // RULE7
  no_bad_release_a:  assert property ((bs == st_t4 && (core_status.odd_low_byte || core_status.interrupt_acknowledge_cycle_first
                       || locked_exec)) |-> !any_grant)
    else $error("release under forbidden condition"); // RULE8
  idle_release_a:    assert property ((waiting[0] && !bus_busy && idle_release) |=> req_grant_pin_high_prio_oe)
    else $error("idle bus not released"); // RULE9
  lock_prefix_a:     assert property ((core_status.lock_prefix && !float_next) |=> (!lock_n_out && lock_n_oe))
    else $error("lock not asserted for prefix"); // RULE12
  lock_float_a:      assert property (bus_float |-> (lock_n_out && !lock_n_oe))
    else $error("lock driven during grant sequence"); // RULE13
  interrupt_acknowledge_cycle_lock_a:       assert property ((bs == st_t2 && core_status.interrupt_acknowledge_cycle_first && !float_next) |=> !lock_n_out)
    else $error("lock not set in first acknowledge"); // RULE14
  queue_delay_a:     assert property (1'b1 |=> ({queue_status_msb, queue_status_lsb} == 2'($past(core_status.queue_op))))
    else $error("queue status not one clock late"); // RULE15
  one_holder_a:      assert property ($onehot0(holding))
    else $error("two masters hold the bus"); // RULE5

  idle_grant_c:      cover property (bs == st_idle ##0 any_grant ##[1:20] any_release);
  mem_grant_c:       cover property (bs == st_t4 ##0 any_grant);
  low_prio_grant_c:  cover property (grant_go[1]);
  interrupt_acknowledge_cycle_lock_c:       cover property (interrupt_acknowledge_cycle_lock_reg ##[1:20] !interrupt_acknowledge_cycle_lock_reg);

endmodule // local_bus_request_grant_lock

// [bench/far_master.sv]
// far-side bus master model driving one request/grant pin
module far_master
(
  input  wire logic clock,
  input  wire logic do_req,
  input  wire logic do_rel,
  input  wire logic grant_oe,
  output logic      pin_level,
  output logic      granted
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pull_reg = 1'b0;
  initial granted = 1'b0;
  // pull-up keeps the wire high unless one side pulls it low
  assign pin_level = ~(pull_reg | grant_oe);
  always @(posedge clock)
  begin
    pull_reg <= (do_req & ~granted) | (do_rel & granted);
    if (grant_oe)
      granted <= 1'b1;
    else if (do_rel & granted)
      granted <= 1'b0;
  end
endmodule // far_master

// [bench/testbench.sv]
// self-checking bench for the local bus request/grant logic
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import arb_pkg::*;
  logic         clock = 0;
  logic         rst = 1;
  core_status_t cs;
  logic [1:0]   req, rel, pin, oe, granted, pout;
  logic         bus_float, resume, lock_n_out, lock_n_oe, qs_msb, qs_lsb;
  int           errors = 0;
  int           total_checks = 0;
  int           cycles = 0;
  always #5 clock = ~clock;
  far_master u_far_master_hi (.clock(clock), .do_req(req[0]), .do_rel(rel[0]), .grant_oe(oe[0]),
    .pin_level(pin[0]), .granted(granted[0]));
  far_master u_far_master_lo (.clock(clock), .do_req(req[1]), .do_rel(rel[1]), .grant_oe(oe[1]),
    .pin_level(pin[1]), .granted(granted[1]));
  local_bus_request_grant_lock u_local_bus_request_grant_lock (.clock(clock), .rst(rst), .core_status(cs),
    .req_grant_pin_high_prio_in(pin[0]), .req_grant_pin_high_prio_out(pout[0]), .req_grant_pin_high_prio_oe(oe[0]),
    .req_grant_pin_low_prio_in(pin[1]), .req_grant_pin_low_prio_out(pout[1]), .req_grant_pin_low_prio_oe(oe[1]),
    .bus_float(bus_float), .resume_in_final_state(resume), .lock_n_out(lock_n_out), .lock_n_oe(lock_n_oe),
    .queue_status_msb(qs_msb), .queue_status_lsb(qs_lsb));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard: the whole run needs about 120 cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(negedge clock);
  endtask
  task automatic pulse(input int ch, input bit is_rel);
    if (is_rel) rel[ch] = 1'b1;
    else req[ch] = 1'b1;
    tick();
    rel[ch] = 1'b0;
    req[ch] = 1'b0;
  endtask
  task automatic idle_exchange(input int ch, input logic pend);
    int n;
    n = 0;
    pulse(ch, 0);
    while (oe[ch] !== 1'b1 && n < 6)
    begin
      tick();
      n++;
    end
    check({oe[ch], bus_float, lock_n_oe, lock_n_out, qs_msb, qs_lsb}, 8'h34);
    tick();
    check({pout, oe, bus_float, lock_n_oe}, 8'h02);
    cs.cycle_pending = pend;
    pulse(ch, 1);
    tick();
    check({bus_float, lock_n_oe, resume}, {5'h0, 2'b01, pend});
    tick();
    check({resume, oe}, 8'h00);
    cs.cycle_pending = 1'b0;
  endtask
  // idle with a pending cycle first, so an early request counts for the cycle
  task automatic mem_cycle(input int req_at, input logic odd, input logic first, input logic lk, output logic got);
    bus_state_t seq[5] = '{st_idle, st_t1, st_t2, st_t3, st_t4};
    got = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      cs.bus_state = seq[i];
      cs.cycle_pending = 1'b1;
      cs.odd_low_byte = odd & (i > 2);
      cs.interrupt_acknowledge_cycle_first = first & (i > 2);
      cs.lock_prefix = lk & (i > 2);
      if (i == req_at) req[0] = 1'b1;
      tick();
      req[0] = 1'b0;
      got |= oe[0];
    end
    cs = '0;
    cs.cycle_pending = 1'b1;
    repeat (4)
    begin
      tick();
      got |= oe[0];
    end
  endtask
  task automatic gated_release();
    logic got;
    for (int k = 0; k < 4; k++)
    begin
      mem_cycle(k == 3 ? 2 : 0, k == 0, k == 1, k == 2, got);
      check(got, 8'h00);
      mem_cycle(-1, 1'b0, 1'b0, 1'b0, got);
      check({got, bus_float}, 8'h03);
      pulse(0, 1);
      tick(2);
      check(bus_float, 8'h00);
    end
    cs = '0;
  endtask
  task automatic queue_test();
    for (int i = 0; i < 4; i++)
    begin
      cs.queue_op = queue_op_t'(i);
      tick();
      check({qs_msb, qs_lsb}, i[7:0]);
    end
    cs.queue_op = op_none;
    tick();
    check({qs_msb, qs_lsb}, 8'h00);
  endtask
  task automatic lock_test();
    cs.lock_prefix = 1'b1;
    tick();
    check({lock_n_out, lock_n_oe}, 8'h01);
    cs.lock_prefix = 1'b0;
    tick();
    check(lock_n_out, 8'h01);
    cs.bus_state = st_t2;
    cs.interrupt_acknowledge_cycle_first = 1'b1;
    tick();
    cs = '0;
    tick(2);
    check(lock_n_out, 8'h00);
    cs.bus_state = st_t2;
    cs.interrupt_acknowledge_cycle_second = 1'b1;
    tick();
    cs = '0;
    check(lock_n_out, 8'h01);
  endtask
  initial
  begin
    cs = '0;
    req = '0;
    rel = '0;
    tick(6);
    check({oe, bus_float, resume, lock_n_out, lock_n_oe, qs_msb, qs_lsb}, 8'h0c);
    rst = 1'b0;
    tick();
    idle_exchange(0, 1'b1);
    idle_exchange(1, 1'b0);
    queue_test();
    lock_test();
    gated_release();
    tally_and_finish();
  end
endmodule // testbench
